// >>> rtl/nvac_ctrl.sv
// Access controller for the 128-byte nonvolatile data memory
// Operation
// - Control bit 3 permits writes; no write starts while it is clear.
// - Setting bit 2 writes data to the addressed byte; hardware clears it afterwards.
// - Write start with permit clear does nothing at all.
// - Control bit 1 permits reads; no read starts while it is clear.
// - Setting bit 0 reads the addressed byte; hardware clears it afterwards.
// - Read start with permit clear starts nothing and keeps the data register.
// - Control bits 7 to 4 always read zero.
// - Reset clears all four control bits, write permit included.
// - A finished read leaves the byte in the data register until the next access.
// - Write length comes from a timer on the asynchronous low-speed clock.
// - Write end sets the write-done flag and the multi-function flag.
// - Vector request needs global, write-done and group enables, stack not full.
// - Service clears only group flag and global enable; software clears write-done.
// - The array holds 128 bytes; address top bit reads zero.
// - Control sits at 40H of sector 1; address and data sit in sector 0.
`timescale 1ns/1ps
module nvac_ctrl
   import nvac_pkg::*;
#(
   parameter int unsigned WRITE_TICKS = NV_WRITE_TICKS,
   parameter int unsigned READ_CYCLES = NV_READ_CYCLES
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Special function register port
   input wire logic sfr_sector,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Low-speed clock pin
   input wire logic low_speed_sub_clock,
   // Interrupt controls from the core
   input wire logic global_irq_enable,
   input wire logic write_done_irq_enable,
   input wire logic mf_irq_enable,
   input wire logic stack_full,
   input wire logic irq_ack,
   input wire logic write_done_flag_clr,
   // Interrupt outputs
   output logic write_done_irq_flag,
   output logic mf_irq_flag,
   output logic irq_vector_req,
   output logic global_irq_enable_clr
);

   nvac_state_t state_ff, nxt_state;
   logic [3:0] ctrl_ff, nxt_ctrl;
   logic [6:0] addr_ff, nxt_addr;
   logic [7:0] data_ff, nxt_data;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [2:0] sub_sync_ff, nxt_sub_sync;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wd_flag_ff, nxt_wd_flag;
   logic mf_flag_ff, nxt_mf_flag;
   logic vec_ff, nxt_vec;
   logic gie_clr_ff, nxt_gie_clr;
   logic sel_addr, sel_data, sel_ctrl;
   logic sub_tick;
   logic mem_rd, mem_wr, wr_done;

   nvac_mem_if mif ();

   nvac_mem #(
      .DEPTH(NV_DEPTH)
   ) u_mem (
      .ref_clk(ref_clk),
      .m(mif.mem)
   );

   // Register decode: control only through sector 1, the rest in sector 0
   assign sel_addr = (sfr_sector == NV_SECTOR_DIRECT) && (sfr_addr == NV_ADDR_REG_OFS);
   assign sel_data = (sfr_sector == NV_SECTOR_DIRECT) && (sfr_addr == NV_DATA_REG_OFS);
   assign sel_ctrl = (sfr_sector == NV_SECTOR_CTRL) && (sfr_addr == NV_CTRL_OFS);

   // Three-stage synchroniser; a rising tick counts when stage two is high and stage three is low
   assign nxt_sub_sync = {sub_sync_ff[1:0], low_speed_sub_clock};
   assign sub_tick = sub_sync_ff[1] & ~sub_sync_ff[2];

   // Array port driven from the frozen address and data registers
   assign mif.rd_en = mem_rd;
   assign mif.wr_en = mem_wr;
   assign mif.addr = addr_ff;
   assign mif.wdata = data_ff;

   // Sequencer and register next values
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ctrl = ctrl_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      mem_rd = 1'b0;
      mem_wr = 1'b0;
      wr_done = 1'b0;
      // Target byte is locked while a write runs
      if (sfr_wr && sel_addr && (state_ff != NVAC_WRITE)) begin
         nxt_addr = sfr_wdata[6:0];
      end
      if (sfr_wr && sel_data && (state_ff != NVAC_WRITE)) begin
         nxt_data = sfr_wdata;
      end
      // Permit bits are plain read/write
      if (sfr_wr && sel_ctrl) begin
         nxt_ctrl[WRITE_PERMIT_BIT] = sfr_wdata[WRITE_PERMIT_BIT];
         nxt_ctrl[READ_PERMIT_BIT] = sfr_wdata[READ_PERMIT_BIT];
      end
      case (state_ff)
         NVAC_IDLE: begin
            // Starts need the permit already set; otherwise the bit stays clear
            if (sfr_wr && sel_ctrl && sfr_wdata[WR_START_BIT] && ctrl_ff[WRITE_PERMIT_BIT]) begin
               nxt_ctrl[WR_START_BIT] = 1'b1;
               nxt_cnt = 16'h0000;
               nxt_state = NVAC_WRITE;
            end else if (sfr_wr && sel_ctrl && sfr_wdata[RD_START_BIT] && ctrl_ff[READ_PERMIT_BIT]) begin
               nxt_ctrl[RD_START_BIT] = 1'b1;
               mem_rd = 1'b1;
               nxt_cnt = 16'h0000;
               nxt_state = NVAC_READ;
            end
         end
         NVAC_READ: begin
            // Read lasts a fixed number of system clocks, then loads the data register
            if (cnt_ff == 16'(READ_CYCLES - 1)) begin
               nxt_data = mif.rdata;
               nxt_ctrl[RD_START_BIT] = 1'b0;
               nxt_state = NVAC_IDLE;
            end else begin
               nxt_cnt = cnt_ff + 16'h0001;
            end
         end
         NVAC_WRITE: begin
            // Write timed on low-speed ticks only; read starts are not looked at here
            if (sub_tick) begin
               if (cnt_ff == 16'(WRITE_TICKS - 1)) begin
                  mem_wr = 1'b1;
                  wr_done = 1'b1;
                  nxt_ctrl[WR_START_BIT] = 1'b0;
                  nxt_state = NVAC_IDLE;
               end else begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end
         end
         default: begin
            nxt_state = NVAC_IDLE;
         end
      endcase
   end

   // Interrupt flags and register read-back next values
   always_comb begin
      // Hardware set wins over a clear in the same cycle
      nxt_wd_flag = wr_done | (wd_flag_ff & ~write_done_flag_clr);
      nxt_mf_flag = wr_done | (mf_flag_ff & ~irq_ack);
      nxt_vec = wd_flag_ff & mf_flag_ff & write_done_irq_enable & mf_irq_enable
         & global_irq_enable & ~stack_full & ~irq_ack;
      nxt_gie_clr = irq_ack;
      nxt_rdata = rdata_ff;
      if (sfr_rd) begin
         if (sel_addr) begin
            nxt_rdata = {1'b0, addr_ff};
         end else if (sel_data) begin
            nxt_rdata = data_ff;
         end else if (sel_ctrl) begin
            nxt_rdata = {4'h0, ctrl_ff};
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_ff <= NVAC_IDLE;
         ctrl_ff <= NV_CTRL_RST;
         addr_ff <= NV_ADDR_RST;
         data_ff <= NV_DATA_RST;
         cnt_ff <= 16'h0000;
         sub_sync_ff <= 3'h0;
         rdata_ff <= 8'h00;
         wd_flag_ff <= 1'b0;
         mf_flag_ff <= 1'b0;
         vec_ff <= 1'b0;
         gie_clr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ctrl_ff <= nxt_ctrl;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         cnt_ff <= nxt_cnt;
         sub_sync_ff <= nxt_sub_sync;
         rdata_ff <= nxt_rdata;
         wd_flag_ff <= nxt_wd_flag;
         mf_flag_ff <= nxt_mf_flag;
         vec_ff <= nxt_vec;
         gie_clr_ff <= nxt_gie_clr;
      end
   end

   // Outputs straight from flip-flops
   assign sfr_rdata = rdata_ff;
   assign write_done_irq_flag = wd_flag_ff;
   assign mf_irq_flag = mf_flag_ff;
   assign irq_vector_req = vec_ff;
   assign global_irq_enable_clr = gie_clr_ff;

   // Checks on the sequencer and flags
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_wr_permit;
      $rose(ctrl_ff[WR_START_BIT]) |-> $past(ctrl_ff[WRITE_PERMIT_BIT]);
   endproperty
   a_wr_permit: assert property (p_wr_permit)
      else $error("Write started without write permit");

   property p_wr_ignored;
      (state_ff == NVAC_IDLE) && sfr_wr && sel_ctrl && sfr_wdata[WR_START_BIT]
         && !ctrl_ff[WRITE_PERMIT_BIT] && !sfr_wdata[RD_START_BIT]
         |=> !ctrl_ff[WR_START_BIT] && (state_ff == NVAC_IDLE) && $stable(data_ff);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored)
      else $error("Write start acted without permit");

   property p_rd_ignored;
      (state_ff == NVAC_IDLE) && sfr_wr && sel_ctrl && sfr_wdata[RD_START_BIT]
         && !ctrl_ff[READ_PERMIT_BIT] && !sfr_wdata[WR_START_BIT]
         |=> !ctrl_ff[RD_START_BIT] && $stable(data_ff) && (state_ff == NVAC_IDLE);
   endproperty
   a_rd_ignored: assert property (p_rd_ignored)
      else $error("Read start acted without permit");

   property p_rd_len;
      $rose(ctrl_ff[RD_START_BIT]) |-> ctrl_ff[RD_START_BIT][*4] ##1 !ctrl_ff[RD_START_BIT];
   endproperty
   a_rd_len: assert property (p_rd_len)
      else $error("Read busy bit did not clear after the read length");

   property p_rd_data;
      $fell(ctrl_ff[RD_START_BIT]) |-> data_ff == $past(mif.rdata);
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("Data register not loaded at read end");

   property p_upper_zero;
      sfr_rd && sel_ctrl |=> sfr_rdata[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("Control upper bits read nonzero");

   property p_reset_clear;
      $rose(rstn) |-> ctrl_ff == NV_CTRL_RST;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Control bits not cleared by reset");

   property p_wr_end;
      $fell(ctrl_ff[WR_START_BIT]) |-> wd_flag_ff && mf_flag_ff && $past(sub_tick);
   endproperty
   a_wr_end: assert property (p_wr_end)
      else $error("Write end did not raise both request flags");

   property p_vector;
      vec_ff |-> $past(global_irq_enable && write_done_irq_enable && mf_irq_enable && !stack_full);
   endproperty
   a_vector: assert property (p_vector)
      else $error("Vector requested without all enables");

   property p_service;
      irq_ack && !wr_done |=> gie_clr_ff && !mf_flag_ff && (wd_flag_ff == $past(wd_flag_ff && !write_done_flag_clr));
   endproperty
   a_service: assert property (p_service)
      else $error("Service did not clear group flag only");

   property p_lock;
      (state_ff == NVAC_WRITE) && sfr_wr && (sel_addr || sel_data || sel_ctrl) |=> $stable(addr_ff)
         && $stable(data_ff) && !ctrl_ff[RD_START_BIT];
   endproperty
   a_lock: assert property (p_lock)
      else $error("Target byte changed or read started during write");

   c_read: cover property ($fell(ctrl_ff[RD_START_BIT]));
   c_write: cover property ($fell(ctrl_ff[WR_START_BIT]));
   c_vector: cover property ($rose(vec_ff));
   c_set_wins: cover property (wr_done && write_done_flag_clr);

endmodule

// >>> rtl/nvac_pkg.sv
// Constants, field positions and types shared by the nonvolatile access controller
package nvac_pkg;

   // Array geometry
   localparam int unsigned NV_DEPTH = 128;
   localparam int unsigned NV_ADDR_W = 7;

   // Register locations: sector select plus offset within the sector
   localparam logic NV_SECTOR_DIRECT = 1'b0;
   localparam logic NV_SECTOR_CTRL = 1'b1;
   localparam logic [7:0] NV_ADDR_REG_OFS = 8'h1E;
   localparam logic [7:0] NV_DATA_REG_OFS = 8'h1F;
   localparam logic [7:0] NV_CTRL_OFS = 8'h40;

   // Control register field positions
   localparam int unsigned RD_START_BIT = 0;
   localparam int unsigned READ_PERMIT_BIT = 1;
   localparam int unsigned WR_START_BIT = 2;
   localparam int unsigned WRITE_PERMIT_BIT = 3;

   // Reset values
   localparam logic [3:0] NV_CTRL_RST = 4'h0;
   localparam logic [6:0] NV_ADDR_RST = 7'h00;
   localparam logic [7:0] NV_DATA_RST = 8'h00;

   // Timing counts: write in low-speed clock ticks, read in system clocks
   localparam int unsigned NV_WRITE_TICKS = 64;
   localparam int unsigned NV_READ_CYCLES = 4;

   // Access sequencer states
   typedef enum logic [1:0] {
      NVAC_IDLE,
      NVAC_READ,
      NVAC_WRITE
   } nvac_state_t;

endpackage

// >>> rtl/nvac_mem_if.sv
// Port bundle between the access sequencer and the byte array
`timescale 1ns/1ps
interface nvac_mem_if;
   import nvac_pkg::*;
   logic rd_en;
   logic wr_en;
   logic [NV_ADDR_W-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
   modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> rtl/nvac_mem.sv
// Byte-wide nonvolatile array model with registered read data
`timescale 1ns/1ps
module nvac_mem
   import nvac_pkg::*;
#(
   parameter int unsigned DEPTH = NV_DEPTH
)(
   // Clock
   input wire logic ref_clk,
   // Sequencer side
   nvac_mem_if.mem m
);

   logic [7:0] cell_ff [DEPTH];
   logic [7:0] rdata_ff;

   // Array write and registered read
   always_ff @(posedge ref_clk) begin
      if (m.wr_en) begin
         cell_ff[m.addr] <= m.wdata;
      end
      if (m.rd_en) begin
         rdata_ff <= cell_ff[m.addr];
      end
   end

   assign m.rdata = rdata_ff;

endmodule

// >>> verif/nvac_core_model.sv
// Core and low-speed oscillator model facing the access controller
`timescale 1ns/1ps
module nvac_core_model (
   // Clock
   input wire logic ref_clk,
   // From the controller
   input wire logic irq_vector_req,
   input wire logic global_irq_enable_clr,
   // To the controller
   output logic global_irq_enable,
   output logic irq_ack,
   output logic low_speed_sub_clock
);
   // Software view of the global enable, masked around a write launch
   task automatic set_gie(logic v);
      global_irq_enable = v;
   endtask

   // Quiet start
   initial begin
      global_irq_enable = 1'b0;
      irq_ack = 1'b0;
      low_speed_sub_clock = 1'b0;
   end

   // Free-running oscillator, stable before any write, phase unrelated to ref_clk
   always #85 low_speed_sub_clock = ~low_speed_sub_clock;

   // Take the vector with a one-cycle acknowledge; service masks further interrupts
   always @(posedge ref_clk) begin
      irq_ack <= #1 irq_vector_req && !irq_ack;
      if (global_irq_enable_clr) begin
         global_irq_enable <= #1 1'b0;
      end
   end
endmodule

// >>> verif/tb_nvac_ctrl.sv
// Self-checking testbench for the nonvolatile access controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e); end end
module tb_nvac_ctrl;
   import nvac_pkg::*;
   localparam int unsigned WT = 2;
   logic ref_clk, rstn, sfr_sector, sfr_wr, sfr_rd;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
   logic low_speed_sub_clock, global_irq_enable, write_done_irq_enable, mf_irq_enable;
   logic stack_full, irq_ack, write_done_flag_clr, write_done_irq_flag, mf_irq_flag;
   logic irq_vector_req, global_irq_enable_clr;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   int k;

   // Design and partner
   nvac_ctrl #(.WRITE_TICKS(WT)) u_dut (.ref_clk, .rstn, .sfr_sector, .sfr_addr, .sfr_wr,
      .sfr_rd, .sfr_wdata, .sfr_rdata, .low_speed_sub_clock, .global_irq_enable,
      .write_done_irq_enable, .mf_irq_enable, .stack_full, .irq_ack, .write_done_flag_clr,
      .write_done_irq_flag, .mf_irq_flag, .irq_vector_req, .global_irq_enable_clr);
   nvac_core_model u_core (.ref_clk, .irq_vector_req, .global_irq_enable_clr,
      .global_irq_enable, .irq_ack, .low_speed_sub_clock);

   // Verdict and end of run
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Step past an edge, then drive
   task automatic tick(int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Register write; strobe stays up for back-to-back accesses
   task automatic wr(logic sec, logic [7:0] a, logic [7:0] d);
      sfr_sector = sec;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_rd = 1'b0;
      sfr_wr = 1'b1;
      tick();
   endtask

   // Register read; data registered at the taking edge
   task automatic rdr(logic sec, logic [7:0] a);
      sfr_sector = sec;
      sfr_addr = a;
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      tick();
      rd = sfr_rdata;
   endtask

   task automatic idle();
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      tick();
   endtask

   // Poll a start bit until hardware clears it
   task automatic wait_clear(int b);
      k = 0;
      do begin
         rdr(1'b1, NV_CTRL_OFS);
         k++;
      end while (rd[b] !== 1'b0 && k < 400);
      `CHK(rd[b], 1'b0);
   endtask

   // Load address and data, then permit and start on consecutive cycles
   task automatic launch(logic [7:0] a, logic [7:0] d);
      wr(1'b0, NV_ADDR_REG_OFS, a);
      wr(1'b0, NV_DATA_REG_OFS, d);
      u_core.set_gie(1'b0);
      wr(1'b1, NV_CTRL_OFS, 8'h08);
      wr(1'b1, NV_CTRL_OFS, 8'h0C);
      u_core.set_gie(1'b1);
   endtask

   // Fresh address for every read
   task automatic do_read(logic [7:0] a);
      wr(1'b0, NV_ADDR_REG_OFS, a);
      wr(1'b1, NV_CTRL_OFS, 8'h02);
      wr(1'b1, NV_CTRL_OFS, 8'h03);
      wait_clear(RD_START_BIT);
      rdr(1'b0, NV_DATA_REG_OFS);
   endtask

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      sfr_sector = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      write_done_irq_enable = 1'b0;
      mf_irq_enable = 1'b0;
      stack_full = 1'b0;
      write_done_flag_clr = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      // Reset values and an unmapped place
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h00);
      rdr(1'b0, NV_ADDR_REG_OFS);
      `CHK(rd, 8'h00);
      rdr(1'b0, 8'h33);
      `CHK(rd, 8'h00);
      $display("Test reset done");
      // Starts without their permits
      wr(1'b1, NV_CTRL_OFS, 8'h01);
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h00);
      rdr(1'b0, NV_DATA_REG_OFS);
      `CHK(rd, 8'h00);
      wr(1'b1, NV_CTRL_OFS, 8'hF2);
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h02);
      wr(1'b1, NV_CTRL_OFS, 8'h06);
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h02);
      wr(1'b1, NV_CTRL_OFS, 8'h00);
      idle();
      `CHK(write_done_irq_flag, 1'b0);
      // Both permits set, then a mid-run reset must clear them
      wr(1'b1, NV_CTRL_OFS, 8'h0A);
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h0A);
      rstn = 1'b0;
      tick(2);
      rstn = 1'b1;
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h00);
      $display("Test refusals done");
      // Write with the vector held off by a full stack, then serviced
      write_done_irq_enable = 1'b1;
      mf_irq_enable = 1'b1;
      stack_full = 1'b1;
      launch(8'hFF, 8'hA5);
      wr(1'b0, NV_ADDR_REG_OFS, 8'h00);
      rdr(1'b0, NV_ADDR_REG_OFS);
      `CHK(rd, 8'h7F);
      rdr(1'b1, NV_CTRL_OFS);
      `CHK(rd, 8'h0C);
      wait_clear(WR_START_BIT);
      `CHK(write_done_irq_flag, 1'b1);
      `CHK(mf_irq_flag, 1'b1);
      idle();
      `CHK(irq_vector_req, 1'b0);
      stack_full = 1'b0;
      k = 0;
      while (irq_vector_req !== 1'b1 && k < 10) begin
         tick();
         k++;
      end
      `CHK(irq_vector_req, 1'b1);
      // Acknowledge lands one cycle later; service effects the cycle after that
      tick(2);
      `CHK(mf_irq_flag, 1'b0);
      `CHK(write_done_irq_flag, 1'b1);
      `CHK(global_irq_enable_clr, 1'b1);
      `CHK(irq_vector_req, 1'b0);
      // Clear pulse is gone and the core has masked its global enable
      tick(2);
      `CHK(global_irq_enable_clr, 1'b0);
      `CHK(global_irq_enable, 1'b0);
      write_done_flag_clr = 1'b1;
      tick();
      write_done_flag_clr = 1'b0;
      tick();
      `CHK(write_done_irq_flag, 1'b0);
      $display("Test write and interrupt done");
      // Second byte, then read both back
      launch(8'h10, 8'h3C);
      wait_clear(WR_START_BIT);
      do_read(8'h7F);
      `CHK(rd, 8'hA5);
      do_read(8'h10);
      `CHK(rd, 8'h3C);
      rdr(1'b0, NV_DATA_REG_OFS);
      `CHK(rd, 8'h3C);
      idle();
      $display("Test read back done");
      test_done();
   end
endmodule
